// File: rtl/ufc_pkg.sv
// shared constants, field positions and state types for the flow control block
package ufc_pkg;

  // rx buffer geometry
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int LVL_W = 4;

  // register indices on the register access port
  localparam logic [3:0] ADDR_DIV_LOW = 4'h0;
  localparam logic [3:0] ADDR_DIV_HIGH = 4'h1;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MODEM_CTL = 4'h4;
  localparam logic [3:0] ADDR_MODEM_STATUS = 4'h5;
  localparam logic [3:0] ADDR_SCRATCH = 4'h6;
  localparam logic [3:0] ADDR_FLOW_LEVELS = 4'h7;
  localparam logic [3:0] ADDR_RX_TRIGGER = 4'h8;
  localparam logic [3:0] ADDR_IO_CONTROL = 4'h9;
  localparam logic [3:0] ADDR_ENH_CTL = 4'ha;
  localparam logic [3:0] ADDR_OFF_FIRST = 4'hb;
  localparam logic [3:0] ADDR_OFF_SECOND = 4'hc;
  localparam logic [3:0] ADDR_ON_FIRST = 4'hd;
  localparam logic [3:0] ADDR_ON_SECOND = 4'he;
  localparam logic [3:0] ADDR_RX_FILL = 4'hf;

  // field positions
  localparam int ENH_SPECIAL = 5;
  localparam int ENH_AUTO_RTS = 6;
  localparam int ENH_AUTO_CTS = 7;
  localparam int IOC_SW_RESET = 3;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int IEN_RX = 0;
  localparam int IEN_SPECIAL = 5;
  localparam int IST_NONE = 0;
  localparam int IST_RX = 2;
  localparam int IST_SPECIAL = 4;

  // receive comparison field encodings
  localparam logic [1:0] RXCMP_NONE = 2'h0;
  localparam logic [1:0] RXCMP_SECOND = 2'h1;
  localparam logic [1:0] RXCMP_FIRST = 2'h2;
  localparam logic [1:0] RXCMP_BOTH = 2'h3;

  // reset values
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [7:0] RST_FLOW_CHAR = 8'h00;
  localparam logic [7:0] RST_INT_EN = 8'h00;
  localparam logic [7:0] RST_MCR = 8'h00;
  localparam logic [7:0] RST_ENH = 8'h00;
  localparam logic [7:0] RST_IOC = 8'h00;
  localparam logic [7:0] RST_LEVELS = 8'h0f;
  localparam logic [7:0] RST_TRIGGER = 8'h00;
  localparam logic [3:0] RST_MODEM_SYNC = 4'hf;
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ufc_regreq_t;

  // registers reset only at power-up
  typedef struct packed {
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] scratch;
    logic [7:0] offFirst;
    logic [7:0] offSecond;
    logic [7:0] onFirst;
    logic [7:0] onSecond;
  } ufc_keep_t;

  // state restored by pin reset and, except the modem synchroniser stages, by software reset
  typedef struct packed {
    logic [7:0] intEn;
    logic [7:0] mcr;
    logic [7:0] enhCtl;
    logic [7:0] ioc;
    logic [7:0] levels;
    logic [7:0] trigger;
    logic [3:0] modSync1;
    logic [3:0] modSync2;
    logic [3:0] modPrev;
    logic [3:0] modDelta;
    logic [1:0] prime;
    logic specFlag;
    logic xoffFlag;
    logic rtsHalt;
    logic swHold;
    logic prevOff1;
    logic prevOn1;
    logic swRst;
    logic txPin;
    logic rtsN;
    logic dtrN;
    logic irqN;
    logic txPause;
    logic [7:0] rdData;
  } ufc_state_t;

  localparam ufc_keep_t KEEP_RST = '{
    divLow: RST_DIV_LOW, divHigh: RST_DIV_HIGH, scratch: RST_SCRATCH,
    offFirst: RST_FLOW_CHAR, offSecond: RST_FLOW_CHAR,
    onFirst: RST_FLOW_CHAR, onSecond: RST_FLOW_CHAR};

  localparam ufc_state_t STATE_RST = '{
    intEn: RST_INT_EN, mcr: RST_MCR, enhCtl: RST_ENH, ioc: RST_IOC,
    levels: RST_LEVELS, trigger: RST_TRIGGER,
    modSync1: RST_MODEM_SYNC, modSync2: RST_MODEM_SYNC,
    modPrev: RST_MODEM_SYNC, modDelta: 4'h0, prime: 2'h0,
    specFlag: 1'b0, xoffFlag: 1'b0, rtsHalt: 1'b0, swHold: 1'b0,
    prevOff1: 1'b0, prevOn1: 1'b0, swRst: 1'b0,
    txPin: 1'b1, rtsN: 1'b1, dtrN: 1'b1, irqN: 1'b1, txPause: 1'b0,
    rdData: 8'h00};

endpackage

// File: rtl/ufc_flow_control.sv
// receive buffer and flow control core of one uart channel
`timescale 1ns/1ns

module ufc_fifo #(
  parameter int WIDTH = ufc_pkg::FIFO_WIDTH,
  parameter int DEPTH = ufc_pkg::FIFO_DEPTH,
  parameter int LW = ufc_pkg::LVL_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [LW-1:0] level
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [LW-1:0] count;
  } ufc_fifo_state_t;

  ufc_fifo_state_t f_q;
  ufc_fifo_state_t f_d;
  logic push;
  logic pop;

  assign inReady = (f_q.count != LW'(DEPTH));
  assign outValid = (f_q.count != '0);
  assign outData = f_q.mem[f_q.rdPtr];
  assign level = f_q.count;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wrPtr] = inData;
      f_d.wrPtr = (f_q.wrPtr == PW'(DEPTH - 1)) ? '0 : f_q.wrPtr + 1'b1;
    end
    if (pop) begin
      f_d.rdPtr = (f_q.rdPtr == PW'(DEPTH - 1)) ? '0 : f_q.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      f_d.count = f_q.count + 1'b1;
    end else if (pop && !push) begin
      f_d.count = f_q.count - 1'b1;
    end
    if (flush) begin
      f_d.wrPtr = '0;
      f_d.rdPtr = '0;
      f_d.count = '0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule // ufc_fifo

// Operation
// - special detect stores match, sets status bit
// - comparison bit order follows received bits
// - first pair mode: both features work together
// - second pair mode: drop match, both interrupts
// - auto request: trigger interrupt, halt raises line
// - auto request: resume level lowers line again
// - without auto mode request line is host-driven
// - auto clear: pause transmit while input high
// - power-up divisor high 0x00, low 0x01
// - reset: change flags zero, upper inverted inputs
// - divisor, scratch, flow chars only power-up reset
// - comparison field encodes first, second, both, none
module ufc_flow_control (
  // clocks and resets
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic por_n,
  // register access port
  input wire ufc_pkg::ufc_regreq_t regReq,
  output logic [7:0] regRdData,
  // received characters from the receiver
  input wire logic rxValid,
  output logic rxReady,
  input wire logic [7:0] rxData,
  // buffered characters toward the host
  output logic rxOutValid,
  input wire logic rxOutReady,
  output logic [7:0] rxOutData,
  // transmitter side
  input wire logic txLineIn,
  output logic txPause,
  output logic txPin,
  // modem pins, order cd ri dsr cts, all active low
  input wire logic [3:0] modemInN,
  output logic rtsN,
  output logic dtrN,
  // interrupt
  output logic irqN,
  // divisor value for the baud generator
  output logic [15:0] divisor
);
  ufc_pkg::ufc_state_t s_q;
  ufc_pkg::ufc_state_t s_d;
  ufc_pkg::ufc_keep_t k_q;
  ufc_pkg::ufc_keep_t k_d;

  logic [ufc_pkg::LVL_W-1:0] fill;
  logic fifoInReady;
  logic offHit;
  logic onHit;
  logic specHit;
  logic dropChar;
  logic accept;
  logic [1:0] cmpSel;

  function automatic logic charHit(input logic [7:0] a, input logic [7:0] b);
    // bit 0 of the stored character meets the first received bit
    return a == b;
  endfunction

  // fill at or above a receive trigger level; level zero means off
  function automatic logic rxTrigHit(input logic [3:0] lvl,
                                     input logic [3:0] trig);
    return (trig != 4'h0) && (lvl >= trig);
  endfunction

  // receive comparison decode
  always_comb begin
    cmpSel = s_q.enhCtl[1:0];
    offHit = 1'b0;
    onHit = 1'b0;
    unique case (cmpSel)
      ufc_pkg::RXCMP_FIRST: begin
        offHit = charHit(k_q.offFirst, rxData);
        onHit = charHit(k_q.onFirst, rxData);
      end
      ufc_pkg::RXCMP_SECOND: begin
        offHit = charHit(k_q.offSecond, rxData);
        onHit = charHit(k_q.onSecond, rxData);
      end
      ufc_pkg::RXCMP_BOTH: begin
        offHit = s_q.prevOff1 && charHit(k_q.offSecond, rxData);
        onHit = s_q.prevOn1 && charHit(k_q.onSecond, rxData);
      end
      ufc_pkg::RXCMP_NONE: begin
        offHit = 1'b0;
        onHit = 1'b0;
      end
    endcase
    specHit = s_q.enhCtl[ufc_pkg::ENH_SPECIAL] &&
              charHit(k_q.offSecond, rxData);
  end

  // flow characters are consumed; a special match in first-pair mode is kept
  assign dropChar = offHit || onHit;
  assign rxReady = dropChar || fifoInReady;
  assign accept = rxValid && rxReady;

  ufc_fifo #(
    .WIDTH(ufc_pkg::FIFO_WIDTH),
    .DEPTH(ufc_pkg::FIFO_DEPTH),
    .LW(ufc_pkg::LVL_W)
  ) rxBuf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flush(s_q.swRst),
    .inValid(rxValid && !dropChar),
    .inReady(fifoInReady),
    .inData(rxData),
    .outValid(rxOutValid),
    .outReady(rxOutReady),
    .outData(rxOutData),
    .level(fill)
  );

  always_comb begin
    s_d = s_q;
    k_d = k_q;

    // modem inputs: two-stage synchroniser, then change detection
    s_d.modSync1 = modemInN;
    s_d.modSync2 = s_q.modSync1;
    s_d.modPrev = s_q.modSync2;
    if (s_q.prime != ufc_pkg::PRIME_CYCLES) begin
      s_d.prime = s_q.prime + 1'b1;
    end

    // register reads: data registered, read side effects cleared here
    if (regReq.rd) begin
      unique case (regReq.addr)
        ufc_pkg::ADDR_DIV_LOW: s_d.rdData = k_q.divLow;
        ufc_pkg::ADDR_DIV_HIGH: s_d.rdData = k_q.divHigh;
        ufc_pkg::ADDR_INT_ENABLE: s_d.rdData = s_q.intEn;
        ufc_pkg::ADDR_INT_STATUS: begin
          s_d.rdData = 8'h00;
          s_d.rdData[ufc_pkg::IST_SPECIAL] = s_q.specFlag || s_q.xoffFlag;
          s_d.rdData[ufc_pkg::IST_RX] = s_q.intEn[ufc_pkg::IEN_RX] &&
                                        rxTrigHit(fill, s_q.trigger[3:0]);
          s_d.rdData[ufc_pkg::IST_NONE] = s_q.irqN;
          s_d.specFlag = 1'b0;
          s_d.xoffFlag = 1'b0;
        end
        ufc_pkg::ADDR_MODEM_CTL: s_d.rdData = s_q.mcr;
        ufc_pkg::ADDR_MODEM_STATUS: begin
          s_d.rdData = {~s_q.modSync2, s_q.modDelta};
          s_d.modDelta = 4'h0;
        end
        ufc_pkg::ADDR_SCRATCH: s_d.rdData = k_q.scratch;
        ufc_pkg::ADDR_FLOW_LEVELS: s_d.rdData = s_q.levels;
        ufc_pkg::ADDR_RX_TRIGGER: s_d.rdData = s_q.trigger;
        ufc_pkg::ADDR_IO_CONTROL: s_d.rdData = s_q.ioc;
        ufc_pkg::ADDR_ENH_CTL: s_d.rdData = s_q.enhCtl;
        ufc_pkg::ADDR_OFF_FIRST: s_d.rdData = k_q.offFirst;
        ufc_pkg::ADDR_OFF_SECOND: s_d.rdData = k_q.offSecond;
        ufc_pkg::ADDR_ON_FIRST: s_d.rdData = k_q.onFirst;
        ufc_pkg::ADDR_ON_SECOND: s_d.rdData = k_q.onSecond;
        ufc_pkg::ADDR_RX_FILL: s_d.rdData = 8'(fill);
      endcase
    end

    // register writes
    if (regReq.wr) begin
      unique case (regReq.addr)
        ufc_pkg::ADDR_DIV_LOW: k_d.divLow = regReq.wdata;
        ufc_pkg::ADDR_DIV_HIGH: k_d.divHigh = regReq.wdata;
        ufc_pkg::ADDR_INT_ENABLE: s_d.intEn = regReq.wdata;
        ufc_pkg::ADDR_MODEM_CTL: s_d.mcr = regReq.wdata;
        ufc_pkg::ADDR_SCRATCH: k_d.scratch = regReq.wdata;
        ufc_pkg::ADDR_FLOW_LEVELS: s_d.levels = regReq.wdata;
        ufc_pkg::ADDR_RX_TRIGGER: s_d.trigger = regReq.wdata;
        ufc_pkg::ADDR_IO_CONTROL: begin
          s_d.ioc = regReq.wdata;
          s_d.ioc[ufc_pkg::IOC_SW_RESET] = 1'b0;
          s_d.swRst = regReq.wdata[ufc_pkg::IOC_SW_RESET];
        end
        ufc_pkg::ADDR_ENH_CTL: s_d.enhCtl = regReq.wdata;
        ufc_pkg::ADDR_OFF_FIRST: k_d.offFirst = regReq.wdata;
        ufc_pkg::ADDR_OFF_SECOND: k_d.offSecond = regReq.wdata;
        ufc_pkg::ADDR_ON_FIRST: k_d.onFirst = regReq.wdata;
        ufc_pkg::ADDR_ON_SECOND: k_d.onSecond = regReq.wdata;
        default: s_d.swRst = s_q.swRst;
      endcase
    end

    // change flags: set wins over a same-cycle read clear
    if (s_q.prime == ufc_pkg::PRIME_CYCLES) begin
      s_d.modDelta = s_d.modDelta | (s_q.modSync2 ^ s_q.modPrev);
    end

    // received character events, set after any read clear
    if (accept) begin
      if (specHit) begin
        s_d.specFlag = 1'b1;
      end
      if (offHit) begin
        s_d.swHold = 1'b1;
        if (specHit) begin
          s_d.xoffFlag = 1'b1;
        end
      end
      if (onHit) begin
        s_d.swHold = 1'b0;
      end
      s_d.prevOff1 = charHit(k_q.offFirst, rxData);
      s_d.prevOn1 = charHit(k_q.onFirst, rxData);
    end

    // automatic request line halt and resume hysteresis
    if (fill >= s_q.levels[3:0]) begin
      s_d.rtsHalt = 1'b1;
    end else if (fill < s_q.levels[7:4]) begin
      s_d.rtsHalt = 1'b0;
    end

    if (s_q.enhCtl[ufc_pkg::ENH_AUTO_RTS]) begin
      // auto mode only acts once the host has asserted the line
      s_d.rtsN = s_q.mcr[ufc_pkg::MCR_RTS] ? s_q.rtsHalt : 1'b1;
    end else begin
      s_d.rtsN = !s_q.mcr[ufc_pkg::MCR_RTS];
    end
    s_d.dtrN = !s_q.mcr[ufc_pkg::MCR_DTR];

    // transmit pause on clear-to-send high or received off character
    s_d.txPause = (s_q.enhCtl[ufc_pkg::ENH_AUTO_CTS] && s_q.modSync2[0]) ||
                  s_q.swHold;
    s_d.txPin = txLineIn;

    // interrupt output, active low
    s_d.irqN = !((s_q.intEn[ufc_pkg::IEN_RX] &&
                  rxTrigHit(fill, s_q.trigger[3:0])) ||
                 (s_q.intEn[ufc_pkg::IEN_SPECIAL] &&
                  (s_q.specFlag || s_q.xoffFlag)));

    // software reset restores everything except power-up registers and the modem synchroniser stages, which keep sampling
    if (s_q.swRst) begin
      s_d = ufc_pkg::STATE_RST;
      s_d.modSync1 = modemInN;
      s_d.modSync2 = s_q.modSync1;
      s_d.modPrev = s_q.modSync2;
    end
  end

  // power-up only registers
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      k_q <= ufc_pkg::KEEP_RST;
    end else begin
      k_q <= k_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= ufc_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign txPause = s_q.txPause;
  assign txPin = s_q.txPin;
  assign rtsN = s_q.rtsN;
  assign dtrN = s_q.dtrN;
  assign irqN = s_q.irqN;
  assign divisor = {k_q.divHigh, k_q.divLow};
endmodule // ufc_flow_control

// File: testbench/ufc_flow_control_assertions.sv
// port-level checks for the uart flow control block
`timescale 1ns/1ns
module ufc_flow_control_checker (
  // clock and resets
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic por_n,
  // register access port
  input wire ufc_pkg::ufc_regreq_t regReq,
  input wire logic [7:0] regRdData,
  // receive stream
  input wire logic rxReady,
  input wire logic rxOutValid,
  // pins
  input wire logic txPause,
  input wire logic txPin,
  input wire logic [3:0] modemInN,
  input wire logic rtsN,
  input wire logic dtrN,
  input wire logic irqN,
  input wire logic [15:0] divisor
);
  logic [2:0] pinAge_q;
  logic [3:0] pinPrev_q;

  // counts edges since the modem pins last moved
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinAge_q <= 3'h0;
      pinPrev_q <= 4'hf;
    end else begin
      pinPrev_q <= modemInN;
      if (modemInN != pinPrev_q) pinAge_q <= 3'h0;
      else if (pinAge_q != 3'h7) pinAge_q <= pinAge_q + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  pins_reset_a: assert property (
    $rose(arst_n) |-> txPin && rtsN && dtrN && irqN && !txPause)
    else $error("outputs not idle after reset");
  div_powerup_a: assert property (
    $rose(por_n) |-> divisor == 16'h0001)
    else $error("divisor wrong after power-up");
  div_keep_a: assert property (
    $rose(arst_n) && $past(por_n) |-> divisor == $past(divisor))
    else $error("divisor lost on pin reset");
  rd_div_low_a: assert property (
    regReq.rd && regReq.addr == ufc_pkg::ADDR_DIV_LOW
    |=> regRdData == $past(divisor[7:0]))
    else $error("low divisor read mismatch");
  rd_div_high_a: assert property (
    regReq.rd && regReq.addr == ufc_pkg::ADDR_DIV_HIGH
    |=> regRdData == $past(divisor[15:8]))
    else $error("high divisor read mismatch");
  div_write_a: assert property (
    regReq.wr && regReq.addr == ufc_pkg::ADDR_DIV_HIGH
    |=> divisor[15:8] == $past(regReq.wdata))
    else $error("high divisor write lost");
  dtr_follow_a: assert property (
    regReq.wr && regReq.addr == ufc_pkg::ADDR_MODEM_CTL
    |-> ##2 dtrN == !$past(regReq.wdata[ufc_pkg::MCR_DTR], 2))
    else $error("terminal ready pin does not follow control");
  empty_ready_a: assert property (
    !rxOutValid |-> rxReady)
    else $error("empty buffer refuses a character");
  msr_level_a: assert property (
    regReq.rd && regReq.addr == ufc_pkg::ADDR_MODEM_STATUS
    && pinAge_q > 3'h4 |=> regRdData[7:4] == ~$past(modemInN))
    else $error("modem status levels not inverted pins");
endmodule // ufc_flow_control_checker

bind ufc_flow_control ufc_flow_control_checker i_ufc_flow_control_checker (
  .core_clk, .arst_n, .por_n, .regReq, .regRdData, .rxReady, .rxOutValid,
  .txPause, .txPin, .modemInN, .rtsN, .dtrN, .irqN, .divisor);

// File: testbench/ufc_line_peer.sv
// line-side peer: feeds received characters, drains the buffer, drives modem
`timescale 1ns/1ns
module ufc_line_peer (
  // clock
  input wire logic core_clk,
  // characters into the block
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData,
  // buffered characters out of the block
  input wire logic rxOutValid,
  output logic rxOutReady,
  input wire logic [7:0] rxOutData,
  // modem pins, active low
  output logic [3:0] modemInN
);
  initial begin
    rxValid = 1'b0;
    rxData = 8'ha5;
    rxOutReady = 1'b0;
    modemInN = 4'hf;
  end

  // holds the character until the block takes it or 50 cycles pass, then scrambles the data
  task automatic send(input logic [7:0] c);
    int n;
    @(posedge core_clk);
    #1 rxValid = 1'b1;
    rxData = c;
    n = 0;
    while (!rxReady && n < 50) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    #1 rxValid = 1'b0;
    rxData = ~c;
  endtask

  // call only while a character is buffered
  task automatic pop(output logic [7:0] c);
    @(posedge core_clk);
    #1 rxOutReady = rxOutValid;
    c = rxOutData;
    @(posedge core_clk);
    #1 rxOutReady = 1'b0;
  endtask

  // all four modem pins at once, cts in bit 0
  task automatic pins(input logic [3:0] v);
    @(posedge core_clk);
    #1 modemInN = v;
  endtask
endmodule // ufc_line_peer

// File: testbench/ufc_flow_control_test.sv
// self-checking bench for the uart flow control block
`timescale 1ns/1ns
module ufc_flow_control_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic por_n = 1'b0;
  logic txLineIn;
  ufc_pkg::ufc_regreq_t regReq = '0;
  logic rxValid, rxReady, rxOutValid, rxOutReady, txPause, txPin;
  logic rtsN, dtrN, irqN;
  logic [7:0] rxData, rxOutData, regRdData, c;
  logic [3:0] modemInN;
  logic [15:0] divisor;
  int miscompares = 0;
  int comparisons = 0;
  // power-up-only registers, then those restored by every reset
  logic [3:0] keepA [7] = '{4'h0, 4'h1, 4'h6, 4'hb, 4'hc, 4'hd, 4'he};
  logic [7:0] keepP [7] = '{8'h01, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] keepW [7] = '{8'h55, 8'haa, 8'h3c, 8'h11, 8'h01, 8'h12, 8'h02};
  logic [3:0] clrA [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha, 4'hf};
  logic [7:0] clrV [9] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00,
                           8'h00, 8'h00};

  always #20 core_clk = ~core_clk;
  // transmitter line follows the stimulus data lsb
  assign txLineIn = rxData[0];

  ufc_flow_control i_ufc_flow_control (.core_clk, .arst_n, .por_n, .regReq,
    .regRdData, .rxValid, .rxReady, .rxData, .rxOutValid, .rxOutReady,
    .rxOutData, .txLineIn, .txPause, .txPin, .modemInN, .rtsN, .dtrN, .irqN,
    .divisor);
  ufc_line_peer i_ufc_line_peer (.core_clk, .rxValid, .rxReady, .rxData,
    .rxOutValid, .rxOutReady, .rxOutData, .modemInN);

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1 regReq = '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1 regReq = '0;
    check(regRdData, exp);
  endtask

  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic swreset;
    wr(4'h9, 8'h08);
    settle();
  endtask

  task automatic regs_after_reset(input bit fresh);
    for (int i = 0; i < 7; i++)
      rd(keepA[i], fresh ? keepP[i] : keepW[i]);
    for (int i = 0; i < 9; i++)
      rd(clrA[i], clrV[i]);
    check({4'h0, txPin, rtsN, dtrN, irqN}, 8'h0f);
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    #1 arst_n = 1'b1;
    por_n = 1'b1;
    regs_after_reset(1'b1);
    $display("test power-up values done");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 7; i++)
        wr(keepA[i], keepW[i]);
      wr(4'h2, 8'h21);
      wr(4'h4, 8'h03);
      wr(4'ha, 8'h40);
      if (k == 0) begin
        @(posedge core_clk);
        #1 arst_n = 1'b0;
        @(posedge core_clk);
        #1 arst_n = 1'b1;
      end else
        swreset();
      regs_after_reset(1'b0);
    end
    $display("test reset kinds done");
    swreset();
    wr(4'ha, 8'h22);
    i_ufc_line_peer.send(8'h80);
    rd(4'h3, 8'h01);
    i_ufc_line_peer.send(8'h01);
    rd(4'h3, 8'h11);
    i_ufc_line_peer.send(8'h11);
    settle();
    check({7'h0, txPause}, 8'h01);
    i_ufc_line_peer.send(8'h12);
    settle();
    check({7'h0, txPause}, 8'h00);
    i_ufc_line_peer.pop(c);
    check(c, 8'h80);
    i_ufc_line_peer.pop(c);
    check(c, 8'h01);
    for (int m = 0; m < 4; m++) begin
      swreset();
      wr(4'ha, 8'(m));
      i_ufc_line_peer.send(8'h11);
      if (m == 3)
        i_ufc_line_peer.send(8'h01);
      settle();
      check({7'h0, txPause}, {7'h0, m[1]});
      rd(4'hf, {7'h0, m != 2});
    end
    swreset();
    wr(4'h2, 8'h20);
    wr(4'ha, 8'h21);
    i_ufc_line_peer.send(8'h01);
    settle();
    check({6'h0, irqN, txPause}, 8'h01);
    rd(4'hf, 8'h00);
    rd(4'h3, 8'h10);
    settle();
    check({7'h0, irqN}, 8'h01);
    $display("test character detection done");
    swreset();
    wr(4'h4, 8'h02);
    settle();
    check({7'h0, rtsN}, 8'h00);
    wr(4'h4, 8'h00);
    settle();
    check({7'h0, rtsN}, 8'h01);
    wr(4'h7, 8'h24);
    wr(4'h8, 8'h03);
    wr(4'h2, 8'h01);
    wr(4'ha, 8'h40);
    wr(4'h4, 8'h02);
    for (int i = 0; i < 8; i++) begin
      i_ufc_line_peer.send(8'h30 + 8'(i));
      settle();
      check({6'h0, irqN, rtsN}, {6'h0, i < 2, i > 2});
      check({7'h0, txPin}, {7'h0, !i[0]});
    end
    check({7'h0, rxReady}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      i_ufc_line_peer.pop(c);
      check(c, 8'h30 + 8'(i));
      settle();
      check({7'h0, rtsN}, {7'h0, i < 6});
    end
    check({7'h0, rxOutValid}, 8'h00);
    swreset();
    wr(4'ha, 8'h80);
    i_ufc_line_peer.pins(4'hf);
    settle();
    check({7'h0, txPause}, 8'h01);
    i_ufc_line_peer.pins(4'h6);
    settle();
    check({7'h0, txPause}, 8'h00);
    rd(4'h5, 8'h99);
    rd(4'h5, 8'h90);
    i_ufc_line_peer.pins(4'hf);
    settle();
    check({7'h0, txPause}, 8'h01);
    $display("test hardware flow control done");
    tally_and_finish();
  end

  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule // ufc_flow_control_test
